/* uibg_top.sv */
`timescale 1ns/1ps
// What this block does
// - The upper four enable bits always read back as zero.
// - Enable bit 3 lets a modem handshake change raise the interrupt.
// - Enable bit 2 lets a receive line error raise the interrupt.
// - Enable bit 1 lets an empty transmit holding buffer raise the interrupt.
// - Enable bit 0 lets received data, threshold or timeout raise the interrupt.
// - With enable bits 3..0 all clear nothing can raise the interrupt.
// - The divisor is two 8-bit read/write bytes forming one 16-bit value.
// - Normal speed divides 24 MHz by the pre-divider (to 1.8461 MHz at 13), then by the divisor 1..65535.
// - The generator output runs at sixteen times the bit rate for transmit and receive.
// - High speed divides the 24 MHz input directly by the same divisor.
// - Bits 7 and 6 of the speed configuration select high or normal speed.
// - High speed with divisor one reaches 1.5 Mbit/s.
// - In normal speed the pre-divider is 13, 1.625 or 1.0 as the prescale configuration selects.
// - A scratch byte is freely written and read with no other effect.
// - The interrupt pin is driven only with control bit 3 set; loopback routes it to carrier detect.
// - Pending sources rank line status, receive data, transmit empty, handshake change.
module uibg_top #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // 24 MHz reference pin
    input  wire logic             clk24_pin,
    // UART side
    input  wire uibg_pkg::uibg_src_t src,
    input  wire logic             rx_timeout,
    output logic                  baud16_tick,
    output logic [3:0]            irq_id,
    output logic                  irq_pin_o,
    output logic                  irq_pin_oe,
    output logic                  loop_dcd,
    output logic                  loop_en,
    output logic                  evt_irq
);

    // Refused at elaboration; the byte registers only fill 16 bits
    if (DIV_W != 16) begin : g_div_w_check
        $error("uibg_top: divisor must be 16 bits wide");
    end

    // Register state
    logic [3:0]       ien_q, ien_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [7:0]       scr_q, scr_d;
    logic [7:0]       spd_q, spd_d;
    logic [1:0]       pre_q, pre_d;
    logic [7:0]       mcr_q, mcr_d;
    logic [3:0]       evt_q, evt_d;
    logic [3:0]       evten_q, evten_d;
    logic [3:0]       srcp_q, srcp_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             rdy_q, rdy_d;
    logic             err_q, err_d;
    logic             wr_en, setup, hit;
    logic [3:0]       src_v, evt_set;

    assign src_v = src;
    assign setup = psel & ~penable & ~rdy_q;
    assign wr_en = psel & penable & rdy_q & pwrite;

    // Address decode, unmapped answers with pslverr
    always_comb begin
        unique case (paddr)
            uibg_pkg::OFS_IRQ_EN, uibg_pkg::OFS_DIV_LOW, uibg_pkg::OFS_DIV_HIGH,
            uibg_pkg::OFS_SCRATCH, uibg_pkg::OFS_SPEED_CFG, uibg_pkg::OFS_PRESCALE,
            uibg_pkg::OFS_MODEM_CTL, uibg_pkg::OFS_IRQ_ID, uibg_pkg::OFS_EVT_STAT,
            uibg_pkg::OFS_EVT_CLR, uibg_pkg::OFS_EVT_EN: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data and handshake, captured in the setup cycle
    always_comb begin
        rdy_d   = setup;
        err_d   = setup ? ~hit : 1'b0;
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            unique case (paddr)
                uibg_pkg::OFS_IRQ_EN:    rdata_d[3:0] = ien_q;
                uibg_pkg::OFS_DIV_LOW:   rdata_d[7:0] = div_q[7:0];
                uibg_pkg::OFS_DIV_HIGH:  rdata_d[7:0] = div_q[15:8];
                uibg_pkg::OFS_SCRATCH:   rdata_d[7:0] = scr_q;
                uibg_pkg::OFS_SPEED_CFG: rdata_d[7:0] = spd_q;
                uibg_pkg::OFS_PRESCALE:  rdata_d[1:0] = pre_q;
                uibg_pkg::OFS_MODEM_CTL: rdata_d[7:0] = mcr_q;
                uibg_pkg::OFS_IRQ_ID:    rdata_d[3:0] = irq_id;
                uibg_pkg::OFS_EVT_STAT:  rdata_d[3:0] = evt_q;
                uibg_pkg::OFS_EVT_EN:    rdata_d[3:0] = evten_q;
                default:                 rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register writes; only byte lane 0 carries data
    always_comb begin
        ien_d   = ien_q;
        div_d   = div_q;
        scr_d   = scr_q;
        spd_d   = spd_q;
        pre_d   = pre_q;
        mcr_d   = mcr_q;
        evten_d = evten_q;
        if (wr_en && pstrb[0]) begin
            unique case (paddr)
                uibg_pkg::OFS_IRQ_EN:    ien_d = pwdata[3:0];
                uibg_pkg::OFS_DIV_LOW:   div_d[7:0] = pwdata[7:0];
                uibg_pkg::OFS_DIV_HIGH:  div_d[15:8] = pwdata[7:0];
                uibg_pkg::OFS_SCRATCH:   scr_d = pwdata[7:0];
                uibg_pkg::OFS_SPEED_CFG: spd_d = pwdata[7:0];
                uibg_pkg::OFS_PRESCALE:  pre_d = pwdata[1:0];
                uibg_pkg::OFS_MODEM_CTL: mcr_d = pwdata[7:0];
                uibg_pkg::OFS_EVT_EN:    evten_d = pwdata[3:0];
                default:                 ien_d = ien_q;
            endcase
        end
    end

    // Sticky edge events; a set in the clearing cycle survives
    always_comb begin
        srcp_d  = src_v;
        evt_set = src_v & ~srcp_q;
        evt_d   = evt_q;
        if (wr_en && pstrb[0] && paddr == uibg_pkg::OFS_EVT_CLR) begin
            evt_d = evt_q & ~pwdata[3:0];
        end
        evt_d = evt_d | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q   <= 4'h0;
            div_q   <= uibg_pkg::RST_DIV;
            scr_q   <= uibg_pkg::RST_BYTE;
            spd_q   <= uibg_pkg::RST_BYTE;
            pre_q   <= uibg_pkg::PRE_SEL_13;
            mcr_q   <= uibg_pkg::RST_BYTE;
            evt_q   <= 4'h0;
            evten_q <= 4'h0;
            srcp_q  <= 4'h0;
            rdata_q <= 32'h0000_0000;
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ien_q   <= ien_d;
            div_q   <= div_d;
            scr_q   <= scr_d;
            spd_q   <= spd_d;
            pre_q   <= pre_d;
            mcr_q   <= mcr_d;
            evt_q   <= evt_d;
            evten_q <= evten_d;
            srcp_q  <= srcp_d;
            rdata_q <= rdata_d;
            rdy_q   <= rdy_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = rdy_q;
    assign pslverr = err_q;

    // Interrupt gate and priority encoder
    logic [3:0] pend;
    logic       loop, irq_d, oe_d, dcd_d, eirq_d;
    logic [3:0] id_d;
    logic       irq_q, oe_q, dcd_q, eirq_q, lp_q;
    logic [3:0] id_q;

    always_comb begin
        pend   = src_v & ien_q;
        loop   = mcr_q[uibg_pkg::BIT_LOOP];
        irq_d  = |pend;
        oe_d   = mcr_q[uibg_pkg::BIT_OUT_EN] & ~loop;
        dcd_d  = mcr_q[uibg_pkg::BIT_OUT_EN] & loop;
        eirq_d = |(evt_q & evten_q);
        if (pend[2]) begin
            id_d = uibg_pkg::ID_LINE;
        end else if (pend[0]) begin
            id_d = rx_timeout ? uibg_pkg::ID_TMO : uibg_pkg::ID_RX;
        end else if (pend[1]) begin
            id_d = uibg_pkg::ID_TX;
        end else if (pend[3]) begin
            id_d = uibg_pkg::ID_MODEM;
        end else begin
            id_d = uibg_pkg::ID_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q  <= 1'b0;
            oe_q   <= 1'b0;
            dcd_q  <= 1'b0;
            eirq_q <= 1'b0;
            lp_q   <= 1'b0;
            id_q   <= uibg_pkg::ID_NONE;
        end else begin
            irq_q  <= irq_d;
            oe_q   <= oe_d;
            dcd_q  <= dcd_d;
            eirq_q <= eirq_d;
            lp_q   <= loop;
            id_q   <= id_d;
        end
    end

    assign irq_pin_o  = irq_q;
    assign irq_pin_oe = oe_q;
    assign loop_dcd   = dcd_q;
    assign loop_en    = lp_q;
    assign evt_irq    = eirq_q;
    assign irq_id     = id_q;

    // 24 MHz pin: two-stage sync, then rising edge detect
    logic [2:0] s24_q, s24_d;
    logic       t24;
    always_comb begin
        s24_d = {s24_q[1:0], clk24_pin};
    end
    assign t24 = s24_q[1] & ~s24_q[2];

    // Fractional pre-divider in eighths, then divisor down-counter
    logic             hs;
    logic [7:0]       lim, acc_q, acc_d, acc_s, acc_r;
    logic             ref_t, b16_d, b16_q;
    logic [DIV_W-1:0] cnt_q, cnt_d;

    localparam logic [DIV_W-1:0] RST_DIV_W = uibg_pkg::RST_DIV;

    always_comb begin
        hs = |spd_q[uibg_pkg::BIT_HS_LO +: 2];
        if (hs) begin
            lim = uibg_pkg::PRE_LIM1;
        end else if (pre_q == uibg_pkg::PRE_SEL_13) begin
            lim = uibg_pkg::PRE_LIM13;
        end else if (pre_q == uibg_pkg::PRE_SEL_1625) begin
            lim = uibg_pkg::PRE_LIM16;
        end else begin
            lim = uibg_pkg::PRE_LIM1;
        end
        acc_s = acc_q + uibg_pkg::PRE_STEP;
        acc_r = acc_s - lim;
        acc_d = acc_q;
        ref_t = 1'b0;
        if (t24) begin
            if (acc_s >= lim) begin
                // Residue from a larger ratio would burst ticks; drop it
                if (acc_r >= lim) begin
                    acc_d = 8'h00;
                end else begin
                    acc_d = acc_r;
                end
                ref_t = 1'b1;
            end else begin
                acc_d = acc_s;
            end
        end
        // Divisor zero stops the clock rather than wrapping to 65536
        cnt_d = cnt_q;
        b16_d = 1'b0;
        if (ref_t && div_q != 16'h0000) begin
            // A count above a freshly lowered divisor restarts at once
            if (cnt_q <= 16'h0001 || cnt_q > div_q) begin
                cnt_d = div_q;
                b16_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s24_q <= 3'h0;
            acc_q <= 8'h00;
            cnt_q <= RST_DIV_W;
            b16_q <= 1'b0;
        end else begin
            s24_q <= s24_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            b16_q <= b16_d;
        end
    end

    assign baud16_tick = b16_q;

    // Check helper: input edges between reference ticks at divide-by-13
    logic [7:0] gap_q, gap_d;
    logic       l13_q, l13_d;

    always_comb begin
        gap_d = gap_q;
        if (ref_t) begin
            gap_d = 8'h00;
        end else if (t24 && gap_q != 8'hff) begin
            gap_d = gap_q + 8'h01; // Saturates, never wraps
        end
        // Armed only after one tick taken at this ratio
        l13_d = l13_q;
        if (lim != uibg_pkg::PRE_LIM13) begin
            l13_d = 1'b0;
        end else if (ref_t) begin
            l13_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 8'h00;
            l13_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            l13_q <= l13_d;
        end
    end

    // Checks
    AST_IEN_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == uibg_pkg::OFS_IRQ_EN |=> prdata[7:4] == 4'h0)
        else $error("upper enable bits not zero");
    AST_MODEM_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        src.modem_change && ien_q[3] |=> irq_q)
        else $error("modem change did not raise request");
    AST_LINE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        src.line_error && ien_q[2] |=> irq_q && id_q == uibg_pkg::ID_LINE)
        else $error("line error not reported first");
    AST_TX_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        src.tx_empty && ien_q[1] |=> irq_q)
        else $error("tx empty did not raise request");
    AST_RX_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        src.rx_ready && ien_q[0] && !ien_q[2] |=> id_q[2] && !id_q[0])
        else $error("rx ready not reported");
    AST_ALL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        ien_q == 4'h0 |=> !irq_q && id_q == uibg_pkg::ID_NONE)
        else $error("request with all sources disabled");
    AST_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(|ien_q) |=> !irq_q)
        else $error("request stayed after enable cleared");
    AST_PIN_OE: assert property (@(posedge pclk) disable iff (!presetn)
        irq_pin_oe |-> $past(mcr_q[uibg_pkg::BIT_OUT_EN]) && !$past(loop))
        else $error("interrupt pin driven while disabled");
    AST_HS_DIV1: assert property (@(posedge pclk) disable iff (!presetn)
        hs && div_q == 16'h0001 && t24 |=> baud16_tick)
        else $error("high speed divisor one missed a tick");
    AST_NORM_REF: assert property (@(posedge pclk) disable iff (!presetn)
        ref_t && l13_q && lim == uibg_pkg::PRE_LIM13
        |-> gap_q == (uibg_pkg::PRE_LIM13 >> 3) - 8'h01)
        else $error("reference tick not every thirteen input edges");
    AST_NO_DIV: assert property (@(posedge pclk) disable iff (!presetn)
        div_q == 16'h0000 |=> !baud16_tick)
        else $error("tick with zero divisor");
    COV_BAUD: cover property (@(posedge pclk) disable iff (!presetn) baud16_tick);
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq_pin_oe && irq_pin_o);
    COV_EVT: cover property (@(posedge pclk) disable iff (!presetn) evt_irq);
    COV_TMO: cover property (@(posedge pclk) disable iff (!presetn)
        id_q == uibg_pkg::ID_TMO);
    COV_NORM13: cover property (@(posedge pclk) disable iff (!presetn)
        ref_t && l13_q);

endmodule

/* uibg_pkg.sv */
package uibg_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_IRQ_EN    = 8'h00;
    localparam logic [7:0] OFS_DIV_LOW   = 8'h04;
    localparam logic [7:0] OFS_DIV_HIGH  = 8'h08;
    localparam logic [7:0] OFS_SCRATCH   = 8'h0c;
    localparam logic [7:0] OFS_SPEED_CFG = 8'h10;
    localparam logic [7:0] OFS_PRESCALE  = 8'h14;
    localparam logic [7:0] OFS_MODEM_CTL = 8'h18;
    localparam logic [7:0] OFS_IRQ_ID    = 8'h1c;
    localparam logic [7:0] OFS_EVT_STAT  = 8'h20;
    localparam logic [7:0] OFS_EVT_CLR   = 8'h24;
    localparam logic [7:0] OFS_EVT_EN    = 8'h28;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIV  = 16'h0000;

    // Field positions
    localparam int BIT_HS_LO   = 6;  // speed_select_config bits 7:6
    localparam int BIT_OUT_EN  = 3;  // modem_control_reg interrupt pin enable
    localparam int BIT_LOOP    = 4;  // modem_control_reg diagnostic loopback
    localparam int IRQ_EN_BITS = 4;  // live bits of irq_source_enable

    // Pre-divider codes in prescale_select_config bits 1:0
    localparam logic [1:0] PRE_SEL_13   = 2'h0;
    localparam logic [1:0] PRE_SEL_1625 = 2'h1;

    // Pre-divider as eighths of a 24 MHz tick: 13, 1.625, 1.0
    localparam logic [7:0] PRE_STEP  = 8'h08;
    localparam logic [7:0] PRE_LIM13 = 8'h68;
    localparam logic [7:0] PRE_LIM16 = 8'h0d;
    localparam logic [7:0] PRE_LIM1  = 8'h08;

    // Interrupt identification codes, bit 0 high means none pending
    localparam logic [3:0] ID_NONE  = 4'h1;
    localparam logic [3:0] ID_LINE  = 4'h6;
    localparam logic [3:0] ID_RX    = 4'h4;
    localparam logic [3:0] ID_TMO   = 4'hc;
    localparam logic [3:0] ID_TX    = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;

    // Source conditions from the rest of the UART
    typedef struct packed {
        logic modem_change;
        logic line_error;
        logic tx_empty;
        logic rx_ready;
    } uibg_src_t;

endpackage

/* uibg_ref24.sv */
`timescale 1ns/1ps
// Reference oscillator and a tally of generator pulses
module uibg_ref24 (
    // Register-side clock and generator output
    input  wire logic pclk,
    input  wire logic baud16_tick,
    // Reference pin and tallies
    output logic      clk24_pin,
    output int        edge_cnt,
    output int        tick_cnt
);
    // Runs free, phase unrelated to pclk
    initial begin
        clk24_pin = 1'b0;
        #3.1;
        forever begin
            #20.833 clk24_pin = ~clk24_pin;
        end
    end
    // Rising reference edges
    always @(posedge clk24_pin) begin
        edge_cnt <= edge_cnt + 1;
    end
    // Pulses that time transmit and receive
    always @(posedge pclk) begin
        if (baud16_tick === 1'b1) begin
            tick_cnt <= tick_cnt + 1;
        end
    end
endmodule

/* uibg_top_tb_top.sv */
`timescale 1ns/1ps
module uibg_top_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} uibg_row_t;
    typedef struct packed {logic [7:0] s; logic [1:0] p; logic [15:0] d; int lo; int hi;} uibg_bd_t;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata;
    logic [3:0]          pstrb, irq_id;
    logic                clk24_pin, rx_timeout, baud16_tick;
    logic                irq_pin_o, irq_pin_oe, loop_dcd, loop_en, evt_irq;
    uibg_pkg::uibg_src_t src;
    int                  edge_cnt, tick_cnt, fail_count, comparisons;
    // Register rows: address, write value, read-back, error
    uibg_row_t rows [5] = '{
        '{uibg_pkg::OFS_IRQ_EN,   32'h0000_00ff, 32'h0000_000f, 1'b0},
        '{uibg_pkg::OFS_DIV_LOW,  32'h0000_005a, 32'h0000_005a, 1'b0},
        '{uibg_pkg::OFS_DIV_HIGH, 32'h0000_00c3, 32'h0000_00c3, 1'b0},
        '{uibg_pkg::OFS_SCRATCH,  32'h0000_00a5, 32'h0000_00a5, 1'b0},
        '{8'h3c,                  32'h0000_005a, 32'h0000_0000, 1'b1}};
    // Speed, prescale, divisor, pulses per 208 reference edges
    uibg_bd_t bds [7] = '{
        '{8'h00, 2'h0, 16'h0001, 15, 17}, '{8'h00, 2'h1, 16'h0001, 127, 129},
        '{8'h00, 2'h2, 16'h0001, 206, 210}, '{8'hc0, 2'h0, 16'h0001, 206, 210},
        '{8'h40, 2'h0, 16'h0002, 103, 105}, '{8'h00, 2'h3, 16'h0100, 0, 1},
        '{8'h80, 2'h1, 16'h0001, 206, 210}};
    logic [3:0] ids [4] = '{uibg_pkg::ID_RX, uibg_pkg::ID_TX, uibg_pkg::ID_LINE,
                            uibg_pkg::ID_MODEM};

    uibg_top uibg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk24_pin(clk24_pin), .src(src),
        .rx_timeout(rx_timeout), .baud16_tick(baud16_tick), .irq_id(irq_id),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .loop_dcd(loop_dcd),
        .loop_en(loop_en), .evt_irq(evt_irq));
    uibg_ref24 uibg_ref24_i (.pclk(pclk), .baud16_tick(baud16_tick), .clk24_pin(clk24_pin),
        .edge_cnt(edge_cnt), .tick_cnt(tick_cnt));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever begin
            #2.5 pclk = ~pclk;
        end
    end
    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, x, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic        e;
        apb(1'b0, a, 32'h0, x, e);
        cmp_data(x, exp);
    endtask
    task automatic irq_chk(input logic o, input logic [3:0] id);
        repeat (3) @(posedge pclk);
        cmp_data({27'h0, irq_pin_o, irq_id}, {27'h0, o, id});
    endtask
    // Hang guard, well past the expected run
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        logic [31:0] x;
        logic        e;
        logic [3:0]  m;
        int          e0, t0;
        fail_count = 0;
        comparisons = 0;
        {presetn, psel, penable, pwrite, rx_timeout} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        src = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cmp_data({28'h0, irq_id}, {28'h0, uibg_pkg::ID_NONE});
        // Reset value, write, read back, error flag
        foreach (rows[i]) begin
            rd_chk(rows[i].a, 32'h0);
            wr(rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0, x, e);
            cmp_data({e, x[30:0]}, {rows[i].e, rows[i].r[30:0]});
        end
        // Each source alone behind its own enable bit
        for (int i = 0; i < 4; i++) begin
            m = 4'h1 << i;
            src <= uibg_pkg::uibg_src_t'(m);
            wr(uibg_pkg::OFS_IRQ_EN, {28'h0, m});
            irq_chk(1'b1, ids[i]);
            wr(uibg_pkg::OFS_IRQ_EN, {28'h0, ~m});
            irq_chk(1'b0, uibg_pkg::ID_NONE);
        end
        src <= 4'hf;
        wr(uibg_pkg::OFS_IRQ_EN, 32'h0);
        irq_chk(1'b0, uibg_pkg::ID_NONE);
        wr(uibg_pkg::OFS_IRQ_EN, 32'hf);
        irq_chk(1'b1, uibg_pkg::ID_LINE);
        src <= 4'h3;
        rx_timeout <= 1'b1;
        irq_chk(1'b1, uibg_pkg::ID_TMO);
        rx_timeout <= 1'b0;
        src <= 4'ha;
        irq_chk(1'b1, uibg_pkg::ID_TX);
        // Pin drive and loopback routing
        wr(uibg_pkg::OFS_MODEM_CTL, 32'h08);
        irq_chk(1'b1, uibg_pkg::ID_TX);
        cmp_data({30'h0, irq_pin_oe, loop_dcd}, 32'h2);
        wr(uibg_pkg::OFS_MODEM_CTL, 32'h18);
        irq_chk(1'b1, uibg_pkg::ID_TX);
        cmp_data({29'h0, loop_en, irq_pin_oe, loop_dcd}, 32'h5);
        // Sticky events: set, enable, clear
        src <= 4'h0;
        wr(uibg_pkg::OFS_EVT_CLR, 32'hf);
        rd_chk(uibg_pkg::OFS_EVT_STAT, 32'h0);
        src <= 4'h8;
        wr(uibg_pkg::OFS_EVT_EN, 32'h8);
        rd_chk(uibg_pkg::OFS_EVT_STAT, 32'h8);
        cmp_data({31'h0, evt_irq}, 32'h1);
        wr(uibg_pkg::OFS_EVT_CLR, 32'h8);
        rd_chk(uibg_pkg::OFS_EVT_STAT, 32'h0);
        cmp_data({31'h0, evt_irq}, 32'h0);
        // Generator rates over 208 reference edges
        foreach (bds[i]) begin
            wr(uibg_pkg::OFS_SPEED_CFG, {24'h0, bds[i].s});
            wr(uibg_pkg::OFS_PRESCALE, {30'h0, bds[i].p});
            wr(uibg_pkg::OFS_DIV_LOW, {24'h0, bds[i].d[7:0]});
            wr(uibg_pkg::OFS_DIV_HIGH, {24'h0, bds[i].d[15:8]});
            repeat (40) @(posedge pclk);
            e0 = edge_cnt;
            t0 = tick_cnt;
            while (edge_cnt - e0 < 208) @(posedge pclk);
            cmp_cnt(tick_cnt - t0, bds[i].lo, bds[i].hi);
        end
        // Mid-run reset: registers clear and the generator stops
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cmp_data({28'h0, irq_id}, {28'h0, uibg_pkg::ID_NONE});
        rd_chk(uibg_pkg::OFS_DIV_HIGH, 32'h0);
        rd_chk(uibg_pkg::OFS_IRQ_EN, 32'h0);
        t0 = tick_cnt;
        repeat (100) @(posedge pclk);
        cmp_cnt(tick_cnt - t0, 0, 0);
        // Lane 0 strobe low leaves the scratch byte alone
        pstrb <= 4'he;
        wr(uibg_pkg::OFS_SCRATCH, 32'h0000_00ff);
        pstrb <= 4'hf;
        rd_chk(uibg_pkg::OFS_SCRATCH, 32'h0);
        print_verdict();
    end
endmodule
